// >>> hdl/cfag_params.svh
// Named constants for the flag and address generation datapath
`ifndef CFAG_PARAMS_SVH
`define CFAG_PARAMS_SVH

`define CFAG_MASK_BYTE 16'h00FF
`define CFAG_MASK_WORD 16'hFFFF
`define CFAG_ZERO_16 16'h0000
`define CFAG_ZERO_32 32'h0000_0000
`define CFAG_ZERO_PAGE 8'h00
`define CFAG_ONE_16 16'h0001
`define CFAG_SIZE_BYTE 2'h0
`define CFAG_SIZE_WORD 2'h1
`define CFAG_SIZE_DWORD 2'h2
`define CFAG_CNT_ONE 3'h1
`define CFAG_CNT_TWO 3'h2
`define CFAG_CNT_FOUR 3'h4
`define CFAG_CNT_ZERO 3'h0
`define CFAG_MUL_ERR_BIT 7
`define CFAG_EMUL_ERR_BIT 15

`endif

// >>> hdl/cfag_pkg.sv
// Types for the flag and address generation datapath
package cfag_pkg;

   typedef enum logic [3:0] {
      CFAG_OP_ADD = 4'h0,
      CFAG_OP_ADC = 4'h1,
      CFAG_OP_SUB = 4'h2,
      CFAG_OP_SBC = 4'h3,
      CFAG_OP_CMP = 4'h4,
      CFAG_OP_LOAD = 4'h5,
      CFAG_OP_INDEX_INC = 4'h6,
      CFAG_OP_INDEX_DEC = 4'h7,
      CFAG_OP_LSL = 4'h8,
      CFAG_OP_LSR = 4'h9,
      CFAG_OP_ROL = 4'hA,
      CFAG_OP_ROR = 4'hB,
      CFAG_OP_ASR = 4'hC,
      CFAG_OP_MUL = 4'hD,
      CFAG_OP_EMUL = 4'hE,
      CFAG_OP_EDIV = 4'hF
   } cfag_op_t;

   typedef enum logic [3:0] {
      CFAG_NO_OPERAND_MODE = 4'h0,
      CFAG_LITERAL_OPERAND_MODE = 4'h1,
      CFAG_PAGE_ZERO_MODE = 4'h2,
      CFAG_FULL_ADDRESS_MODE = 4'h3,
      CFAG_BRANCH_SHORT_MODE = 4'h4,
      CFAG_BRANCH_LONG_MODE = 4'h5,
      CFAG_BASE_OFFSET_MODE = 4'h6,
      CFAG_BASE_OFFSET_EXT1_MODE = 4'h7,
      CFAG_BASE_OFFSET_EXT2_MODE = 4'h8,
      CFAG_PRE_INC_MODE = 4'h9,
      CFAG_PRE_DEC_MODE = 4'hA,
      CFAG_POST_INC_MODE = 4'hB,
      CFAG_POST_DEC_MODE = 4'hC,
      CFAG_ACCUM_OFFSET_MODE = 4'hD,
      CFAG_POINTER_VIA_OFFSET_MODE = 4'hE,
      CFAG_POINTER_VIA_ACCUM_MODE = 4'hF
   } cfag_mode_t;

   typedef enum logic [1:0] {
      CFAG_BASE_X = 2'h0,
      CFAG_BASE_Y = 2'h1,
      CFAG_BASE_SP = 2'h2,
      CFAG_BASE_PC = 2'h3
   } cfag_base_t;

   typedef enum logic [1:0] {
      CFAG_ST_IDLE = 2'h0,
      CFAG_ST_PTR = 2'h1,
      CFAG_ST_DATA = 2'h2
   } cfag_state_t;

endpackage

// >>> hdl/cfag_core.sv
// Condition flags, operand layout and effective address generation
// What this block does
// - Negative flag copies the result's top bit.
// - Zero flag set when every result bit is zero.
// - Compare subtracts internally and sets all flags from it.
// - Index increment and decrement change only the zero flag.
// - Overflow flag set on two's complement overflow.
// - Carry flag set on add carry or subtract borrow.
// - Multiply and divide report errors through carry.
// - Shifts and rotates move bits out through carry; only rotates move bits in from carry.
// - Two's complement; offsets up to 16 bits; 32-bit products and dividends.
// - Address space is 64 Kbytes with 16-bit addresses.
// - Bytes readable at any address.
// - Words are two bytes, high byte first, any alignment.
// - Double words are four bytes, high byte first, any alignment.
// - Peripherals reached by ordinary memory reads, no special cycle.
// - One instruction finishes before the next starts.
// - All modes but inherent give a 16-bit address; inherent no access.
// - Direct mode: operand byte low, high byte zero.
// - Extended mode uses the full 16-bit address given.
// - Relative mode: program counter plus signed 8 or 16-bit offset.
// - Indexed: base plus signed 5, 9 or 16-bit constant.
// - Auto modes step base X, Y or SP by 1 to 8, before or after.
// - Indirect reads a 16-bit pointer; accumulator offset adds directly.
`timescale 1ns/10ps
`include "cfag_params.svh"

module cfag_core
   import cfag_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic op_start_i,
   input wire cfag_op_t op_i,
   input wire logic op_word_i,
   input wire logic [15:0] opa_i,
   input wire logic [15:0] opb_i,
   input wire logic [15:0] divisor_i,
   input wire logic ag_start_i,
   input wire cfag_mode_t mode_i,
   input wire cfag_base_t base_sel_i,
   input wire logic [15:0] offset_i,
   input wire logic [2:0] step_i,
   input wire logic [15:0] accum_i,
   input wire logic [15:0] pc_i,
   input wire logic [15:0] x_i,
   input wire logic [15:0] y_i,
   input wire logic [15:0] sp_i,
   input wire logic [1:0] acc_size_i,
   input wire logic fetch_i,
   input wire logic [7:0] mem_rdata_i,
   output logic ready_o,
   output logic [31:0] result_o,
   output logic result_we_o,
   output logic op_done_o,
   output logic flag_n_o,
   output logic flag_z_o,
   output logic flag_v_o,
   output logic flag_c_o,
   output logic [15:0] ea_o,
   output logic ag_done_o,
   output logic [31:0] operand_o,
   output logic base_we_o,
   output logic [1:0] base_sel_o,
   output logic [15:0] base_val_o,
   output logic mem_rd_o,
   output logic [15:0] mem_addr_o
);

   function automatic logic top_of(input logic [15:0] x, input logic w);
      top_of = w ? x[15] : x[7];
   endfunction

   function automatic logic zero_of(input logic [15:0] x, input logic w);
      zero_of = ((x & (w ? `CFAG_MASK_WORD : `CFAG_MASK_BYTE)) ==
         `CFAG_ZERO_16);
   endfunction

   // Arithmetic section
   logic flag_n_ff, flag_z_ff, flag_v_ff, flag_c_ff;
   logic [31:0] result_ff;
   logic result_we_ff, op_done_ff;
   cfag_state_t state_ff;

   // One instruction at a time: both engines share the ready term
   logic ag_idle, ag_busy_ff;
   assign ag_idle = (state_ff == CFAG_ST_IDLE) && !ag_busy_ff;
   assign ready_o = ag_idle && !op_done_ff;
   wire op_take = op_start_i && ready_o;
   wire ag_take = ag_start_i && ready_o && !op_start_i;

   wire [15:0] amask = op_word_i ? `CFAG_MASK_WORD : `CFAG_MASK_BYTE;
   wire [15:0] aw = opa_i & amask;
   wire [15:0] bw = opb_i & amask;
   wire with_c = (op_i == CFAG_OP_ADC) || (op_i == CFAG_OP_SBC);
   wire cin = with_c && flag_c_ff;
   wire [16:0] sum = {1'b0, aw} + {1'b0, bw} + {16'h0000, cin};
   wire [16:0] dif = {1'b0, aw} - {1'b0, bw} - {16'h0000, cin};
   wire a_top = top_of(aw, op_word_i);
   wire b_top = top_of(bw, op_word_i);
   wire sum_top = top_of(sum[15:0], op_word_i);
   wire dif_top = top_of(dif[15:0], op_word_i);
   wire sum_cy = op_word_i ? sum[16] : sum[8];
   wire dif_bw = op_word_i ? dif[16] : dif[8];
   wire [15:0] idx_inc = opa_i + `CFAG_ONE_16;
   wire [15:0] idx_dec = opa_i - `CFAG_ONE_16;
   // Incoming shift bit comes from carry for rotates, sign for ASR
   wire rot_in = ((op_i == CFAG_OP_ROL) || (op_i == CFAG_OP_ROR)) &&
      flag_c_ff;
   wire shr_in = (op_i == CFAG_OP_ASR) ? a_top : rot_in;
   wire [15:0] shl = ((aw << 1) | {15'h0000, rot_in}) & amask;
   wire [15:0] shr = (aw >> 1) |
      (op_word_i ? {shr_in, 15'h0000} : {8'h00, shr_in, 7'h00});
   wire sh_out_l = a_top;
   wire sh_out_r = aw[0];
   wire [15:0] mul8 = 16'(opa_i[7:0] * opb_i[7:0]);
   wire [31:0] mul16 = 32'(opa_i * opb_i);
   wire div_zero = (divisor_i == `CFAG_ZERO_16);
   wire [15:0] dsafe = div_zero ? `CFAG_ONE_16 : divisor_i;
   wire [31:0] dvd = {opa_i, opb_i};
   wire [31:0] quo = dvd / {16'h0000, dsafe};
   wire [31:0] rem = dvd % {16'h0000, dsafe};
   wire quo_ovf = (quo[31:16] != `CFAG_ZERO_16);

   logic [31:0] nxt_result;
   logic nxt_n, nxt_z, nxt_v, nxt_c, nxt_we;

   always_comb begin
      nxt_result = `CFAG_ZERO_32;
      nxt_n = flag_n_ff;
      nxt_z = flag_z_ff;
      nxt_v = flag_v_ff;
      nxt_c = flag_c_ff;
      nxt_we = 1'b1;
      case (op_i)
         CFAG_OP_ADD, CFAG_OP_ADC: begin
            nxt_result = {16'h0000, sum[15:0] & amask};
            nxt_n = sum_top;
            nxt_z = zero_of(sum[15:0], op_word_i);
            nxt_v = (a_top == b_top) && (sum_top != a_top);
            nxt_c = sum_cy;
         end
         CFAG_OP_SUB, CFAG_OP_SBC, CFAG_OP_CMP: begin
            nxt_result = {16'h0000, dif[15:0] & amask};
            nxt_we = (op_i != CFAG_OP_CMP);
            nxt_n = dif_top;
            nxt_z = zero_of(dif[15:0], op_word_i);
            nxt_v = (a_top != b_top) && (dif_top != a_top);
            nxt_c = dif_bw;
         end
         CFAG_OP_LOAD: begin
            nxt_result = {16'h0000, aw};
            nxt_n = a_top;
            nxt_z = zero_of(aw, op_word_i);
            nxt_v = 1'b0;
         end
         CFAG_OP_INDEX_INC: begin
            nxt_result = {16'h0000, idx_inc};
            nxt_z = (idx_inc == `CFAG_ZERO_16);
         end
         CFAG_OP_INDEX_DEC: begin
            nxt_result = {16'h0000, idx_dec};
            nxt_z = (idx_dec == `CFAG_ZERO_16);
         end
         CFAG_OP_LSL, CFAG_OP_ROL: begin
            nxt_result = {16'h0000, shl};
            nxt_n = top_of(shl, op_word_i);
            nxt_z = zero_of(shl, op_word_i);
            nxt_c = sh_out_l;
            nxt_v = top_of(shl, op_word_i) ^ sh_out_l;
         end
         CFAG_OP_LSR, CFAG_OP_ROR, CFAG_OP_ASR: begin
            nxt_result = {16'h0000, shr};
            nxt_n = top_of(shr, op_word_i);
            nxt_z = zero_of(shr, op_word_i);
            nxt_c = sh_out_r;
            nxt_v = top_of(shr, op_word_i) ^ sh_out_r;
         end
         CFAG_OP_MUL: begin
            nxt_result = {16'h0000, mul8};
            nxt_c = mul8[`CFAG_MUL_ERR_BIT];
         end
         CFAG_OP_EMUL: begin
            nxt_result = mul16;
            nxt_n = mul16[31];
            nxt_z = (mul16 == `CFAG_ZERO_32);
            nxt_c = mul16[`CFAG_EMUL_ERR_BIT];
         end
         default: begin
            // Extended divide: remainder high, quotient low
            nxt_result = {rem[15:0], quo[15:0]};
            nxt_n = quo[15];
            nxt_z = (quo[15:0] == `CFAG_ZERO_16);
            nxt_v = quo_ovf && !div_zero;
            nxt_c = div_zero;
         end
      endcase
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         flag_n_ff <= 1'b0;
         flag_z_ff <= 1'b0;
         flag_v_ff <= 1'b0;
         flag_c_ff <= 1'b0;
         result_ff <= `CFAG_ZERO_32;
         result_we_ff <= 1'b0;
         op_done_ff <= 1'b0;
      end else begin
         op_done_ff <= op_take;
         result_we_ff <= op_take && nxt_we;
         if (op_take) begin
            flag_n_ff <= nxt_n;
            flag_z_ff <= nxt_z;
            flag_v_ff <= nxt_v;
            flag_c_ff <= nxt_c;
            result_ff <= nxt_result;
         end
      end
   end

   assign flag_n_o = flag_n_ff;
   assign flag_z_o = flag_z_ff;
   assign flag_v_o = flag_v_ff;
   assign flag_c_o = flag_c_ff;
   assign result_o = result_ff;
   assign result_we_o = result_we_ff;
   assign op_done_o = op_done_ff;

   // Address generation section
   wire [15:0] base_v = (base_sel_i == CFAG_BASE_X) ? x_i :
      (base_sel_i == CFAG_BASE_Y) ? y_i :
      (base_sel_i == CFAG_BASE_SP) ? sp_i : pc_i;
   wire [15:0] off5 = {{11{offset_i[4]}}, offset_i[4:0]};
   wire [15:0] off9 = {{7{offset_i[8]}}, offset_i[8:0]};
   wire [15:0] rel8 = {{8{offset_i[7]}}, offset_i[7:0]};
   wire [15:0] amt = {13'h0000, step_i} + `CFAG_ONE_16;
   // 16-bit sums drop the carry, so addresses wrap
   wire [15:0] b_plus_amt = base_v + amt;
   wire [15:0] b_minus_amt = base_v - amt;
   wire [15:0] b_plus_acc = base_v + accum_i;
   wire [15:0] b_plus_off = base_v + offset_i;
   wire auto_mode = (mode_i == CFAG_PRE_INC_MODE) ||
      (mode_i == CFAG_PRE_DEC_MODE) || (mode_i == CFAG_POST_INC_MODE) ||
      (mode_i == CFAG_POST_DEC_MODE);
   wire inc_mode = (mode_i == CFAG_PRE_INC_MODE) ||
      (mode_i == CFAG_POST_INC_MODE);
   wire ptr_mode = (mode_i == CFAG_POINTER_VIA_OFFSET_MODE) ||
      (mode_i == CFAG_POINTER_VIA_ACCUM_MODE);
   wire no_op_mode = (mode_i == CFAG_NO_OPERAND_MODE);
   wire branch_mode = (mode_i == CFAG_BRANCH_SHORT_MODE) ||
      (mode_i == CFAG_BRANCH_LONG_MODE);
   wire [2:0] size_cnt = (acc_size_i == `CFAG_SIZE_DWORD) ?
      `CFAG_CNT_FOUR : (acc_size_i == `CFAG_SIZE_WORD) ?
      `CFAG_CNT_TWO : `CFAG_CNT_ONE;

   logic [15:0] ea_c;
   always_comb begin
      case (mode_i)
         CFAG_LITERAL_OPERAND_MODE: ea_c = pc_i;
         CFAG_PAGE_ZERO_MODE:
            ea_c = {`CFAG_ZERO_PAGE, offset_i[7:0]};
         CFAG_FULL_ADDRESS_MODE: ea_c = offset_i;
         CFAG_BRANCH_SHORT_MODE: ea_c = pc_i + rel8;
         CFAG_BRANCH_LONG_MODE: ea_c = pc_i + offset_i;
         CFAG_BASE_OFFSET_MODE: ea_c = base_v + off5;
         CFAG_BASE_OFFSET_EXT1_MODE: ea_c = base_v + off9;
         CFAG_BASE_OFFSET_EXT2_MODE: ea_c = b_plus_off;
         CFAG_PRE_INC_MODE: ea_c = b_plus_amt;
         CFAG_PRE_DEC_MODE: ea_c = b_minus_amt;
         CFAG_POST_INC_MODE, CFAG_POST_DEC_MODE: ea_c = base_v;
         CFAG_ACCUM_OFFSET_MODE: ea_c = b_plus_acc;
         CFAG_POINTER_VIA_OFFSET_MODE: ea_c = b_plus_off;
         CFAG_POINTER_VIA_ACCUM_MODE: ea_c = b_plus_acc;
         default: ea_c = `CFAG_ZERO_16;
      endcase
   end

   // Shared byte reader: pointer bytes, then operand bytes, high first
   logic [15:0] rd_base_ff, ea_ff, base_val_ff, mem_addr_ff;
   logic [2:0] rd_n_ff, iss_ff, rcv_ff, data_n_ff;
   logic [31:0] sh_ff, operand_ff;
   logic fetch_ff, rsp_ff, mem_rd_ff, ag_done_ff, base_we_ff;
   logic [1:0] base_sel_ff;

   wire issue = (state_ff != CFAG_ST_IDLE) && (iss_ff != rd_n_ff);
   wire last_rsp = rsp_ff && (rcv_ff == rd_n_ff - `CFAG_CNT_ONE);
   wire [15:0] ptr_val = {sh_ff[7:0], mem_rdata_i};
   wire [31:0] sh_nxt = {sh_ff[23:0], mem_rdata_i};
   wire start_rd = ag_take && !no_op_mode && !branch_mode && fetch_i;

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         state_ff <= CFAG_ST_IDLE;
         ag_busy_ff <= 1'b0;
         rd_base_ff <= `CFAG_ZERO_16;
         rd_n_ff <= `CFAG_CNT_ZERO;
         data_n_ff <= `CFAG_CNT_ZERO;
         iss_ff <= `CFAG_CNT_ZERO;
         rcv_ff <= `CFAG_CNT_ZERO;
         sh_ff <= `CFAG_ZERO_32;
         operand_ff <= `CFAG_ZERO_32;
         ea_ff <= `CFAG_ZERO_16;
         fetch_ff <= 1'b0;
         rsp_ff <= 1'b0;
         mem_rd_ff <= 1'b0;
         mem_addr_ff <= `CFAG_ZERO_16;
         ag_done_ff <= 1'b0;
         base_we_ff <= 1'b0;
         base_sel_ff <= CFAG_BASE_X;
         base_val_ff <= `CFAG_ZERO_16;
      end else begin
         // Plain reads only; peripherals sit in the same map
         mem_rd_ff <= issue;
         mem_addr_ff <= rd_base_ff + {13'h0000, iss_ff};
         rsp_ff <= mem_rd_ff;
         ag_busy_ff <= ag_take;
         ag_done_ff <= 1'b0;
         base_we_ff <= 1'b0;
         if (issue) begin
            iss_ff <= iss_ff + `CFAG_CNT_ONE;
         end
         if (rsp_ff) begin
            sh_ff <= sh_nxt;
            rcv_ff <= rcv_ff + `CFAG_CNT_ONE;
         end
         if (ag_take) begin
            ea_ff <= ea_c;
            fetch_ff <= fetch_i;
            data_n_ff <= size_cnt;
            operand_ff <= `CFAG_ZERO_32;
            sh_ff <= `CFAG_ZERO_32;
            iss_ff <= `CFAG_CNT_ZERO;
            rcv_ff <= `CFAG_CNT_ZERO;
            base_sel_ff <= base_sel_i;
            base_val_ff <= inc_mode ? b_plus_amt : b_minus_amt;
            base_we_ff <= auto_mode && (base_sel_i != CFAG_BASE_PC);
            if (ptr_mode) begin
               state_ff <= CFAG_ST_PTR;
               rd_base_ff <= ea_c;
               rd_n_ff <= `CFAG_CNT_TWO;
            end else if (start_rd) begin
               state_ff <= CFAG_ST_DATA;
               rd_base_ff <= ea_c;
               rd_n_ff <= size_cnt;
            end else begin
               ag_done_ff <= 1'b1;
            end
         end else if (last_rsp) begin
            case (state_ff)
               CFAG_ST_PTR: begin
                  ea_ff <= ptr_val;
                  if (fetch_ff) begin
                     state_ff <= CFAG_ST_DATA;
                     rd_base_ff <= ptr_val;
                     rd_n_ff <= data_n_ff;
                     iss_ff <= `CFAG_CNT_ZERO;
                     rcv_ff <= `CFAG_CNT_ZERO;
                     sh_ff <= `CFAG_ZERO_32;
                  end else begin
                     state_ff <= CFAG_ST_IDLE;
                     ag_done_ff <= 1'b1;
                  end
               end
               default: begin
                  operand_ff <= sh_nxt;
                  state_ff <= CFAG_ST_IDLE;
                  ag_done_ff <= 1'b1;
               end
            endcase
         end
      end
   end

   assign ea_o = ea_ff;
   assign ag_done_o = ag_done_ff;
   assign operand_o = operand_ff;
   assign base_we_o = base_we_ff;
   assign base_sel_o = base_sel_ff;
   assign base_val_o = base_val_ff;
   assign mem_rd_o = mem_rd_ff;
   assign mem_addr_o = mem_addr_ff;

   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   wire [16:0] add_ref = {1'b0, opa_i} + {1'b0, opb_i};

   a_neg_load_msb: assert property (
      op_take && op_i == CFAG_OP_LOAD && op_word_i |=>
      flag_n_o == result_o[15] && op_done_o)
      else $error("negative flag differs from result msb");
   a_zero_add_word: assert property (
      op_take && op_i == CFAG_OP_ADD && op_word_i |=>
      flag_z_o == (result_o[15:0] == `CFAG_ZERO_16))
      else $error("zero flag wrong after add");
   a_cmp_no_write: assert property (
      op_take && op_i == CFAG_OP_CMP && op_word_i |=> !result_we_o &&
      flag_c_o == ($past(opa_i) < $past(opb_i)) &&
      flag_z_o == ($past(opa_i) == $past(opb_i)))
      else $error("compare flags or write wrong");
   a_index_z_only: assert property (
      op_take && (op_i == CFAG_OP_INDEX_INC || op_i == CFAG_OP_INDEX_DEC)
      |=> $stable(flag_n_o) && $stable(flag_v_o) && $stable(flag_c_o))
      else $error("index step touched other flags");
   a_add_overflow: assert property (
      op_take && op_i == CFAG_OP_ADD && op_word_i |=> flag_v_o ==
      ($past(opa_i[15]) == $past(opb_i[15]) &&
      result_o[15] != $past(opa_i[15])))
      else $error("overflow flag wrong after add");
   a_add_carry: assert property (
      op_take && op_i == CFAG_OP_ADD && op_word_i |=>
      flag_c_o == $past(add_ref[16]))
      else $error("carry flag wrong after add");
   a_div_zero_err: assert property (
      op_take && op_i == CFAG_OP_EDIV && divisor_i == `CFAG_ZERO_16
      |=> flag_c_o)
      else $error("divide by zero not flagged");
   a_shift_out_carry: assert property (
      op_take && op_i == CFAG_OP_LSR |=> flag_c_o == $past(opa_i[0]))
      else $error("shifted bit not in carry");
   a_page_zero_ea: assert property (
      ag_take && mode_i == CFAG_PAGE_ZERO_MODE |=>
      ea_o == {`CFAG_ZERO_PAGE, $past(offset_i[7:0])})
      else $error("direct address wrong");
   a_inherent_no_rd: assert property (
      ag_take && mode_i == CFAG_NO_OPERAND_MODE |=> ag_done_o ##1 !mem_rd_o)
      else $error("inherent mode touched memory");
   a_ptr_two_reads: assert property (
      ag_take && ptr_mode && !fetch_i |=> !ag_done_o ##1 mem_rd_o[*2]
      ##1 !mem_rd_o ##1 ag_done_o)
      else $error("pointer fetch sequence wrong");
   a_busy_refuse: assert property (
      ag_take |=> !ready_o)
      else $error("new request accepted during address work");

   c_ptr_fetch: cover property (
      ag_take && ptr_mode && fetch_i ##[4:20] ag_done_o);
   c_dword_read: cover property (
      ag_take && acc_size_i == `CFAG_SIZE_DWORD && fetch_i
      ##[3:12] ag_done_o);
   c_ediv: cover property (op_take && op_i == CFAG_OP_EDIV);

endmodule // cfag_core

// >>> bench/cfag_mem_model.sv
// Memory model answering byte reads one cycle later
`timescale 1ns/10ps
module cfag_mem_model (
   input wire logic mclk_i,
   input wire logic mem_rd_i,
   input wire logic [15:0] mem_addr_i,
   output logic [7:0] rdata_o
);
   // Byte pattern from address, stale data inverted between reads
   wire logic [7:0] nxt_rdata = mem_addr_i[7:0] ^ mem_addr_i[15:8] ^ 8'hA5;
   logic [7:0] rdata_ff = 8'h00;
   always_ff @(posedge mclk_i) begin
      if (mem_rd_i) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= ~rdata_ff;
      end
   end
   assign rdata_o = rdata_ff;
endmodule // cfag_mem_model

// >>> bench/cpu_flags_and_address_gen_test.sv
// Self-checking bench for the flag and address datapath
`timescale 1ns/10ps
module cpu_flags_and_address_gen_test;
   import cfag_pkg::*;
   typedef struct {logic [31:0] r; logic [3:0] f; logic [4:0] m;
      logic w;} cfag_alu_t;
   typedef struct {logic [15:0] ea; logic [31:0] od; logic [15:0] bv;
      logic fe; logic [1:0] bs;} cfag_ag_t;
   logic mclk_i = 1'b0, reset_i = 1'b1, op_start_i = 1'b0, op_word_i = 1'b1;
   logic ag_start_i = 1'b0, fetch_i = 1'b0;
   cfag_op_t op_i = CFAG_OP_ADD;
   cfag_mode_t mode_i = CFAG_NO_OPERAND_MODE;
   cfag_base_t base_sel_i = CFAG_BASE_X;
   logic [15:0] opa_i = 16'h0000, opb_i = 16'h0000, divisor_i = 16'h0000;
   logic [15:0] offset_i = 16'h0000, accum_i = 16'h0000, pc_i = 16'h0000;
   logic [15:0] x_i = 16'h0000, y_i = 16'h0000, sp_i = 16'h0000;
   logic [2:0] step_i = 3'h0;
   logic [1:0] acc_size_i = 2'h0;
   logic [7:0] mem_rdata_i;
   logic ready_o, result_we_o, op_done_o, ag_done_o, base_we_o, mem_rd_o;
   logic flag_n_o, flag_z_o, flag_v_o, flag_c_o;
   wire [3:0] flags = {flag_n_o, flag_z_o, flag_v_o, flag_c_o};
   logic [3:0] fl;
   logic [31:0] result_o, operand_o;
   logic [15:0] ea_o, base_val_o, mem_addr_o, a, b;
   logic [16:0] s;
   logic [1:0] base_sel_o;
   int error_cnt = 0, compares = 0, seed = 62086;
   cfag_alu_t aq[$], ae;
   cfag_ag_t gq[$], ge;
   always #25 mclk_i = ~mclk_i;
   cfag_core dut (.mclk_i, .reset_i, .op_start_i, .op_i, .op_word_i, .opa_i,
      .opb_i, .divisor_i, .ag_start_i, .mode_i, .base_sel_i, .offset_i,
      .step_i, .accum_i, .pc_i, .x_i, .y_i, .sp_i, .acc_size_i, .fetch_i,
      .mem_rdata_i, .ready_o, .result_o, .result_we_o, .op_done_o, .flag_n_o,
      .flag_z_o, .flag_v_o, .flag_c_o, .ea_o, .ag_done_o, .operand_o,
      .base_we_o, .base_sel_o, .base_val_o, .mem_rd_o, .mem_addr_o);
   cfag_mem_model mem (.mclk_i, .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o),
      .rdata_o(mem_rdata_i));
   function automatic logic [7:0] mb(input logic [15:0] ad);
      return ad[7:0] ^ ad[15:8] ^ 8'hA5;
   endfunction
   task automatic chk(input logic [31:0] got, exp, input string what);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic final_report();
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic wait_ready();
      int n = 0;
      #1;
      while (ready_o !== 1'b1 && n < 60) begin
         @(posedge mclk_i);
         #1;
         n++;
      end
      if (ready_o !== 1'b1) chk(0, 1, "hang");
   endtask
   task automatic alu(input cfag_op_t o, input logic [15:0] x, y,
         input logic [31:0] r, input logic [3:0] f, input logic [4:0] m,
         input logic h);
      @(posedge mclk_i);
      op_i <= o;
      opa_i <= x;
      opb_i <= y;
      op_start_i <= 1'b1;
      aq.push_back('{r, f, m, o != CFAG_OP_CMP});
      @(posedge mclk_i);
      if (h) @(posedge mclk_i);
      op_start_i <= 1'b0;
      wait_ready();
   endtask
   task automatic ag(input cfag_mode_t md, input cfag_base_t bs,
         input logic [15:0] off, input logic [2:0] st, input logic [1:0] sz,
         input logic fe, input logic [15:0] ea, bv);
      logic [31:0] od = 32'h0;
      logic rd = fe && md != CFAG_NO_OPERAND_MODE &&
         md != CFAG_BRANCH_SHORT_MODE && md != CFAG_BRANCH_LONG_MODE;
      for (int i = 0; i < (sz == 2'h2 ? 4 : sz + 1); i++)
         od = {od[23:0], mb(16'(ea + i))};
      @(posedge mclk_i);
      mode_i <= md;
      base_sel_i <= bs;
      offset_i <= off;
      step_i <= st;
      acc_size_i <= sz;
      fetch_i <= fe;
      ag_start_i <= 1'b1;
      gq.push_back('{ea, od, bv, rd, bs});
      @(posedge mclk_i);
      ag_start_i <= 1'b0;
      wait_ready();
   endtask
   always @(posedge mclk_i) if (!reset_i) begin
      if (op_done_o && aq.size() == 0) chk(0, 1, "extra op");
      else if (op_done_o) begin
         ae = aq.pop_front();
         if (ae.m[4]) chk(result_o, ae.r, "result");
         chk(result_we_o, ae.w, "write");
         chk(flags & ae.m[3:0], ae.f & ae.m[3:0], "flags");
      end
      if (base_we_o) chk(base_val_o, gq[0].bv, "base");
      if (base_we_o) chk(base_sel_o, gq[0].bs, "base sel");
      if (ag_done_o) begin
         ge = gq.pop_front();
         chk(ea_o, ge.ea, "ea");
         if (ge.fe) chk(operand_o, ge.od, "operand");
      end
   end
   initial begin
      #(6000 * 50);
      chk(0, 1, "timeout");
      final_report();
   end
   initial begin
      repeat (20) @(posedge mclk_i);
      reset_i <= 1'b0;
      x_i <= 16'h2000;
      y_i <= 16'h0100;
      sp_i <= 16'hFFFF;
      pc_i <= 16'h1000;
      accum_i <= 16'hFFFF;
      alu(CFAG_OP_ADD, 16'h7FFF, 16'h0001, 16'h8000, 4'hA, 5'h1F, 0);
      alu(CFAG_OP_SUB, 16'h0000, 16'h0001, 16'hFFFF, 4'h9, 5'h1F, 0);
      alu(CFAG_OP_INDEX_INC, 16'hFFFF, 16'h0, 16'h0, 4'hD, 5'h1F, 0);
      alu(CFAG_OP_CMP, 16'h1234, 16'h1234, 16'h0, 4'h4, 5'h0F, 1);
      alu(CFAG_OP_INDEX_DEC, 16'h0002, 16'h0, 16'h1, 4'h0, 5'h1F, 0);
      alu(CFAG_OP_LSL, 16'h8001, 16'h0, 16'h0002, 4'h3, 5'h1F, 0);
      alu(CFAG_OP_ADC, 16'hFFFF, 16'h0, 16'h0000, 4'h5, 5'h1F, 0);
      alu(CFAG_OP_ROL, 16'h0000, 16'h0, 16'h0001, 4'h0, 5'h1F, 0);
      alu(CFAG_OP_LSR, 16'h0003, 16'h0, 16'h0001, 4'h3, 5'h1F, 0);
      alu(CFAG_OP_SBC, 16'h0000, 16'h0, 16'hFFFF, 4'h9, 5'h1F, 0);
      alu(CFAG_OP_ROR, 16'h0002, 16'h0, 16'h8001, 4'hA, 5'h1F, 0);
      alu(CFAG_OP_ASR, 16'h8000, 16'h0, 16'hC000, 4'hA, 5'h1F, 0);
      alu(CFAG_OP_MUL, 16'h0010, 16'h0008, 16'h0080, 4'h1, 5'h11, 0);
      alu(CFAG_OP_EMUL, 16'hFFFF, 16'h2, 32'h1FFFE, 4'h1, 5'h1D, 0);
      alu(CFAG_OP_EDIV, 16'h0001, 16'h0000, 16'h0, 4'h1, 5'h01, 0);
      divisor_i <= 16'h0010;
      alu(CFAG_OP_EDIV, 16'h1, 16'h23, 32'h31002, 4'h0, 5'h1F, 0);
      alu(CFAG_OP_LOAD, 16'h0000, 16'h0, 16'h0, 4'h4, 5'h1E, 0);
      op_word_i <= 1'b0;
      alu(CFAG_OP_ADD, 16'h00FF, 16'h0001, 16'h0, 4'h5, 5'h1F, 0);
      op_word_i <= 1'b1;
      repeat (8) begin
         a = $random(seed);
         b = $random(seed);
         s = {1'b0, a} + b;
         fl = {s[15], s[15:0] == 16'h0, a[15] == b[15] && s[15] != a[15],
            s[16]};
         alu(CFAG_OP_ADD, a, b, s[15:0], fl, 5'h1F, 0);
      end
      ag(CFAG_PAGE_ZERO_MODE, CFAG_BASE_X, 16'h1234, 0, 1, 1,
         16'h0034, 0);
      ag(CFAG_FULL_ADDRESS_MODE, CFAG_BASE_X, 16'hFFFF, 0, 2, 1,
         16'hFFFF, 0);
      ag(CFAG_BRANCH_SHORT_MODE, CFAG_BASE_X, 16'h00FE, 0, 0, 0,
         16'h0FFE, 0);
      ag(CFAG_BRANCH_LONG_MODE, CFAG_BASE_X, 16'hF000, 0, 0, 1,
         16'h0000, 0);
      ag(CFAG_NO_OPERAND_MODE, CFAG_BASE_X, 16'h1234, 0, 1, 1,
         16'h0000, 0);
      ag(CFAG_BASE_OFFSET_MODE, CFAG_BASE_X, 16'h0010, 0, 0, 1,
         16'h1FF0, 0);
      ag(CFAG_BASE_OFFSET_EXT1_MODE, CFAG_BASE_Y, 16'h01FF, 0, 0, 0,
         16'h00FF, 0);
      ag(CFAG_BASE_OFFSET_EXT2_MODE, CFAG_BASE_SP, 16'h2, 0, 0, 0,
         16'h1, 0);
      ag(CFAG_PRE_INC_MODE, CFAG_BASE_X, 16'h0, 7, 0, 0,
         16'h2008, 16'h2008);
      ag(CFAG_PRE_DEC_MODE, CFAG_BASE_Y, 16'h0, 1, 0, 0,
         16'h00FE, 16'h00FE);
      ag(CFAG_POST_DEC_MODE, CFAG_BASE_SP, 16'h0, 0, 1, 1,
         16'hFFFF, 16'hFFFE);
      ag(CFAG_ACCUM_OFFSET_MODE, CFAG_BASE_Y, 16'h0, 0, 0, 0,
         16'h00FF, 0);
      ag(CFAG_POINTER_VIA_OFFSET_MODE, CFAG_BASE_X, 16'h40, 0, 0, 0,
         {mb(16'h2040), mb(16'h2041)}, 0);
      ag(CFAG_POINTER_VIA_ACCUM_MODE, CFAG_BASE_SP, 16'h0, 0, 1, 1,
         {mb(16'hFFFE), mb(16'hFFFF)}, 0);
      ag(CFAG_LITERAL_OPERAND_MODE, CFAG_BASE_X, 16'h0, 0, 0, 0,
         16'h1000, 0);
      repeat (4) @(posedge mclk_i);
      chk(aq.size() + gq.size(), 0, "missing done");
      final_report();
   end
endmodule // cpu_flags_and_address_gen_test
